// ===== pkg/dee_defs.svh
// Register offsets, field positions, reset values and timing for the EEPROM access controller
`ifndef DEE_DEFS_SVH
`define DEE_DEFS_SVH

`define DEE_OFF_FLAG 8'h0C
`define DEE_OFF_DATA 8'h9A
`define DEE_OFF_ADDR 8'h9B
`define DEE_OFF_CTRL 8'h9C
`define DEE_OFF_UNLOCK 8'h9D

`define DEE_CTRL_RD 0
`define DEE_CTRL_WR 1
`define DEE_CTRL_WRITE_ENABLE_BIT 2
`define DEE_CTRL_ERR 3
`define DEE_FLAG_DONE 7

`define DEE_KEY_FIRST 8'h55
`define DEE_KEY_SECOND 8'hAA
`define DEE_GAP_KEYS 3'h2
`define DEE_GAP_TRIG 3'h1

`define DEE_DATA_RST 8'h00
`define DEE_ADDR_RST 8'h00
`define DEE_ERASED 8'hFF

`define DEE_CLK_MHZ 10
`define DEE_PWRT_TIME_US 72000
`define DEE_WRITE_TIME_US 5000
`define DEE_TIMER_W 20

`endif

// ===== pkg/dee_pkg.sv
// Types shared by the EEPROM access controller
`default_nettype none
`include "dee_defs.svh"

package dee_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_FIRST = 2'b01,
		SEQ_SECOND = 2'b10
	} dee_seq_t;

	typedef struct packed {
		logic extSync1;
		logic extSync2;
		logic [7:0] dataReg;
		logic [7:0] addrReg;
		logic errFlag;
		logic write_enable_bit;
		logic wrBit;
		logic rdBit;
		logic doneFlag;
		dee_seq_t seqState;
		logic [2:0] seqCnt;
		logic [`DEE_TIMER_W-1:0] pwrtCnt;
		logic pwrtDone;
		logic [`DEE_TIMER_W-1:0] wrCnt;
		logic [6:0] wrAddr;
		logic [7:0] wrData;
		logic [7:0] rdData;
		logic [7:0] progData;
	} dee_state_t;

endpackage

`default_nettype wire

// ===== hw/dee_access_ctrl.sv
// Indirect access controller for the 128-byte data EEPROM
//
// Behaviour
// - 128-byte array; processor reaches it only through registers
// - Byte write erases location, then programs it
// - Internal timer times write; trigger stays set
// - Only address bits 6..0 select a location
// - Control bits 7..4 read as zero
// - Triggers set only by software, hardware clears
// - Enable cleared at power-up, by pin/watchdog reset and by a control write with bit 2 clear
// - Pin or watchdog reset mid-write sets error
// - Aborting reset clears data and address registers
// - Completion sets done flag; software clears it
// - Unlock port has no storage, reads zero
// - Read trigger loads data by next cycle
// - Data register holds value until reread/rewritten or pin/watchdog reset
// - Write needs 55h, AAh, then write trigger
// - Sequence cycle count must match exactly
// - Write trigger sets only when enable set
// - Clearing enable does not abort a write
// - No write while power-up timer runs
// - Protection denies programmer, not processor
//
// Design decision made here: strobed register access.
`default_nettype none
`include "dee_defs.svh"

module dee_access_ctrl #(
	parameter int unsigned ADDR_W = 7,
	parameter int unsigned PWRT_CYCLES =
		`DEE_PWRT_TIME_US * `DEE_CLK_MHZ,
	parameter int unsigned WRITE_CYCLES =
		`DEE_WRITE_TIME_US * `DEE_CLK_MHZ
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic extResetPin_b,
	input wire logic watchdogReset,
	input wire logic dataProtect,
	input wire logic progRd,
	input wire logic [ADDR_W-1:0] progAddr,
	output logic [7:0] progRdData,
	output logic writeBusy,
	output logic writeDoneFlag
);

	localparam int unsigned DEPTH = 1 << ADDR_W;
	localparam int unsigned TW = `DEE_TIMER_W;

	dee_pkg::dee_state_t st_reg;
	dee_pkg::dee_state_t st_next;

	logic [7:0] mem [DEPTH];
	logic memWe;
	logic [ADDR_W-1:0] memAddr;
	logic [7:0] memData;

	logic [7:0] rdDataNext;
	logic inReset;
	logic wrData;
	logic wrAddr;
	logic wrCtrl;
	logic wrFlag;
	logic wrUnlock;
	logic armed;
	logic startWrite;
	logic startRead;
	logic writeEnd;
	logic [ADDR_W-1:0] selAddr;
	logic trigWr;
	logic trigRd;

	always_comb begin
		st_next = st_reg;
		memWe = 1'b0;
		memAddr = '0;
		memData = `DEE_ERASED;
		rdDataNext = 8'h00;
		inReset = 1'b0;
		armed = 1'b0;
		startWrite = 1'b0;
		startRead = 1'b0;
		writeEnd = 1'b0;
		// One select per mapped address; unmapped writes are dropped
		wrData = 1'b0;
		wrAddr = 1'b0;
		wrCtrl = 1'b0;
		wrFlag = 1'b0;
		wrUnlock = 1'b0;
		unique case (regAddr)
			`DEE_OFF_DATA: begin
				wrData = regWr;
			end
			`DEE_OFF_ADDR: begin
				wrAddr = regWr;
			end
			`DEE_OFF_CTRL: begin
				wrCtrl = regWr;
			end
			`DEE_OFF_FLAG: begin
				wrFlag = regWr;
			end
			`DEE_OFF_UNLOCK: begin
				wrUnlock = regWr;
			end
			default: begin
			end
		endcase
		// Address bit 7 never reaches the array
		selAddr = st_reg.addrReg[ADDR_W-1:0];
		// Trigger bits of a control write; zeros never clear a trigger
		trigWr = regWrData[`DEE_CTRL_WR];
		trigRd = regWrData[`DEE_CTRL_RD];

		// External reset pin passes two flip-flops first
		st_next.extSync1 = ~extResetPin_b;
		st_next.extSync2 = st_reg.extSync1;

		// Power-up timer runs once after the power-on reset
		if (!st_reg.pwrtDone) begin
			if (st_reg.pwrtCnt == TW'(PWRT_CYCLES - 1)) begin
				st_next.pwrtDone = 1'b1;
			end else begin
				st_next.pwrtCnt = st_reg.pwrtCnt + TW'(1);
			end
		end

		// Unlock sequence tracking with an exact cycle count
		if (st_reg.seqState != dee_pkg::SEQ_IDLE) begin
			st_next.seqCnt = st_reg.seqCnt + 3'h1;
		end
		unique case (st_reg.seqState)
			dee_pkg::SEQ_IDLE: begin
			end
			dee_pkg::SEQ_FIRST: begin
				if (st_reg.seqCnt > `DEE_GAP_KEYS) begin
					st_next.seqState = dee_pkg::SEQ_IDLE;
				end
			end
			dee_pkg::SEQ_SECOND: begin
				if (st_reg.seqCnt > `DEE_GAP_TRIG) begin
					st_next.seqState = dee_pkg::SEQ_IDLE;
				end
			end
			default: begin
				st_next.seqState = dee_pkg::SEQ_IDLE;
			end
		endcase
		if (wrUnlock) begin
			st_next.seqState = dee_pkg::SEQ_IDLE;
			if (regWrData == `DEE_KEY_FIRST) begin
				st_next.seqState = dee_pkg::SEQ_FIRST;
				st_next.seqCnt = 3'h1;
			end else if (regWrData == `DEE_KEY_SECOND &&
				st_reg.seqState == dee_pkg::SEQ_FIRST &&
				st_reg.seqCnt == `DEE_GAP_KEYS) begin
				st_next.seqState = dee_pkg::SEQ_SECOND;
				st_next.seqCnt = 3'h1;
			end
		end
		armed = st_reg.seqState == dee_pkg::SEQ_SECOND &&
			st_reg.seqCnt == `DEE_GAP_TRIG;

		// Plain register writes
		if (wrData) begin
			st_next.dataReg = regWrData;
		end
		if (wrAddr) begin
			st_next.addrReg = regWrData;
		end
		if (wrCtrl) begin
			st_next.seqState = dee_pkg::SEQ_IDLE;
			st_next.errFlag = regWrData[`DEE_CTRL_ERR];
			// Enable is software-owned; a running write ignores it
			st_next.write_enable_bit = regWrData[`DEE_CTRL_WRITE_ENABLE_BIT];
			startWrite = trigWr && !st_reg.wrBit &&
				st_reg.write_enable_bit && armed && st_reg.pwrtDone;
			startRead = trigRd && !st_reg.wrBit &&
				!st_reg.rdBit;
		end

		// Read completes at once; trigger shows for one cycle
		if (st_reg.rdBit) begin
			st_next.rdBit = 1'b0;
		end
		if (startRead) begin
			st_next.rdBit = 1'b1;
			st_next.dataReg = mem[selAddr];
		end

		// Write: erase at start, program when the timer ends
		if (startWrite) begin
			st_next.wrBit = 1'b1;
			st_next.wrCnt = '0;
			st_next.wrAddr = 7'(selAddr);
			st_next.wrData = st_reg.dataReg;
			memWe = 1'b1;
			memAddr = selAddr;
			memData = `DEE_ERASED;
		end
		if (st_reg.wrBit) begin
			if (st_reg.wrCnt == TW'(WRITE_CYCLES - 1)) begin
				writeEnd = 1'b1;
			end else begin
				st_next.wrCnt = st_reg.wrCnt + TW'(1);
			end
		end
		if (writeEnd) begin
			st_next.wrBit = 1'b0;
			memWe = 1'b1;
			memAddr = ADDR_W'(st_reg.wrAddr);
			memData = st_reg.wrData;
		end

		// Done flag: software clears it, completion wins
		if (wrFlag) begin
			st_next.doneFlag = regWrData[`DEE_FLAG_DONE];
		end
		if (writeEnd) begin
			st_next.doneFlag = 1'b1;
		end

		// Pin or watchdog reset: registers except the error flag return to reset values
		inReset = st_reg.extSync2 || watchdogReset;
		// The location under write keeps its erased value when cut short
		// Power-up timer is left alone: only rst_b restarts it
		if (inReset) begin
			memWe = 1'b0;
			st_next.errFlag = st_reg.errFlag || st_reg.wrBit;
			st_next.dataReg = `DEE_DATA_RST;
			st_next.addrReg = `DEE_ADDR_RST;
			st_next.write_enable_bit = 1'b0;
			st_next.wrBit = 1'b0;
			st_next.rdBit = 1'b0;
			st_next.doneFlag = 1'b0;
			st_next.seqState = dee_pkg::SEQ_IDLE;
			st_next.seqCnt = 3'h0;
			st_next.wrCnt = '0;
		end

		// Register read data stands in the following cycle only
		if (regRd) begin
			unique case (regAddr)
				`DEE_OFF_DATA: begin
					rdDataNext = st_reg.dataReg;
				end
				`DEE_OFF_ADDR: begin
					rdDataNext = st_reg.addrReg;
				end
				`DEE_OFF_CTRL: begin
					rdDataNext = 8'h00;
					rdDataNext[`DEE_CTRL_ERR] = st_reg.errFlag;
					rdDataNext[`DEE_CTRL_WRITE_ENABLE_BIT] = st_reg.write_enable_bit;
					rdDataNext[`DEE_CTRL_WR] = st_reg.wrBit;
					rdDataNext[`DEE_CTRL_RD] = st_reg.rdBit;
				end
				`DEE_OFF_FLAG: begin
					rdDataNext = 8'h00;
					rdDataNext[`DEE_FLAG_DONE] = st_reg.doneFlag;
				end
				`DEE_OFF_UNLOCK: begin
					rdDataNext = 8'h00;
				end
				default: begin
					rdDataNext = 8'h00;
				end
			endcase
		end
		st_next.rdData = rdDataNext;

		// Programmer reads are blanked while protection is on
		st_next.progData = 8'h00;
		if (progRd && !dataProtect) begin
			st_next.progData = mem[progAddr];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '{
				extSync1: 1'b0,
				extSync2: 1'b0,
				dataReg: `DEE_DATA_RST,
				addrReg: `DEE_ADDR_RST,
				errFlag: 1'b0,
				write_enable_bit: 1'b0,
				wrBit: 1'b0,
				rdBit: 1'b0,
				doneFlag: 1'b0,
				seqState: dee_pkg::SEQ_IDLE,
				seqCnt: 3'h0,
				pwrtCnt: '0,
				pwrtDone: 1'b0,
				wrCnt: '0,
				wrAddr: 7'h00,
				wrData: 8'h00,
				rdData: 8'h00,
				progData: 8'h00
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// Array has no reset: its contents are nonvolatile
	always_ff @(posedge clk) begin
		if (memWe) begin
			mem[memAddr] <= memData;
		end
	end

	assign regRdData = st_reg.rdData;
	assign progRdData = st_reg.progData;
	assign writeBusy = st_reg.wrBit;
	assign writeDoneFlag = st_reg.doneFlag;

endmodule

`default_nettype wire

// ===== test/dee_access_monitor.sv
// Port checker for the EEPROM access controller
`default_nettype none
module dee_access_monitor #(
	parameter int unsigned ADDR_W = 7
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic extResetPin_b,
	input wire logic watchdogReset,
	input wire logic dataProtect,
	input wire logic progRd,
	input wire logic [ADDR_W-1:0] progAddr,
	input wire logic [7:0] progRdData,
	input wire logic writeBusy,
	input wire logic writeDoneFlag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_unlock_zero;
		$past(regRd) && $past(regAddr) == 8'h9D |-> regRdData == 8'h00;
	endproperty
	a_unlock_zero: assert property (p_unlock_zero)
		else $error("unlock port read not zero");
	property p_ctrl_hi;
		$past(regRd) && $past(regAddr) == 8'h9C |-> regRdData[7:4] == 4'h0;
	endproperty
	a_ctrl_hi: assert property (p_ctrl_hi)
		else $error("control upper bits not zero");
	property p_rd_stand;
		!regRd |=> regRdData == 8'h00;
	endproperty
	a_rd_stand: assert property (p_rd_stand)
		else $error("read data outside its cycle");
	property p_busy_hold;
		$fell(writeBusy) && $past(rst_b) && !$past(watchdogReset)
			&& $past(extResetPin_b, 3) |-> $past(writeBusy, 8);
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("write ended early");
	property p_start_seq;
		$rose(writeBusy) |-> $past(regWrData[1]) && $past(regAddr) == 8'h9C
			&& $past(regWrData, 2) == 8'hAA && $past(regWrData, 4) == 8'h55
			&& $past(regAddr, 4) == 8'h9D;
	endproperty
	a_start_seq: assert property (p_start_seq)
		else $error("write started without unlock");
	property p_done_set;
		$fell(writeBusy) && $past(rst_b) && !$past(watchdogReset)
			&& $past(extResetPin_b, 3) |-> writeDoneFlag;
	endproperty
	a_done_set: assert property (p_done_set)
		else $error("done flag not set at write end");
	property p_done_hold;
		writeDoneFlag && !watchdogReset && $past(extResetPin_b, 2)
			&& !(regWr && regAddr == 8'h0C && !regWrData[7]) |=> writeDoneFlag;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("done flag cleared by hardware");
	property p_prog_zero;
		!progRd || dataProtect |=> progRdData == 8'h00;
	endproperty
	a_prog_zero: assert property (p_prog_zero)
		else $error("programmer read not blocked");
	c_write: cover property ($rose(writeBusy));
	c_done: cover property ($rose(writeDoneFlag));
	c_abort: cover property (writeBusy && watchdogReset);
endmodule
bind dee_access_ctrl dee_access_monitor #(.ADDR_W(ADDR_W)) i_mon (
	.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.extResetPin_b(extResetPin_b), .watchdogReset(watchdogReset),
	.dataProtect(dataProtect), .progRd(progRd), .progAddr(progAddr),
	.progRdData(progRdData), .writeBusy(writeBusy),
	.writeDoneFlag(writeDoneFlag));
`default_nettype wire

// ===== test/dee_access_ctrl_tb_top.sv
// Self-checking bench for the EEPROM access controller
`default_nettype none
module dee_access_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, rst_b = 1'h0, regWr = 1'h0, regRd = 1'h0;
	logic extResetPin_b = 1'h1, watchdogReset = 1'h0, dataProtect = 1'h0;
	logic progRd = 1'h0, writeBusy, writeDoneFlag, rdSeen = 1'h0;
	logic prSeen = 1'h0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, progRdData;
	logic [7:0] d;
	logic [6:0] progAddr = 7'h00, a;
	logic [7:0] rq[$], pq[$];
	logic [7:0] regs[6] = '{8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h0C, 8'h10};
	int errors = 0, nTests = 0, seed = 32'h38e6;
	dee_access_ctrl #(.PWRT_CYCLES(20), .WRITE_CYCLES(10)) i_dut (.*);
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic op(input logic w, r, input logic [7:0] ad, dt);
		regWr <= w;
		regRd <= r;
		regAddr <= ad;
		regWrData <= dt;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] ad, ex);
		rq.push_back(ex);
		op(1'h0, 1'h1, ad, 8'h00);
	endtask
	task automatic unl(input int gap, input logic [7:0] trig);
		op(1'h1, 1'h0, 8'h9D, 8'h55);
		repeat (gap) op(1'h0, 1'h0, 8'h00, 8'h00);
		op(1'h1, 1'h0, 8'h9D, 8'hAA);
		op(1'h1, 1'h0, 8'h9C, trig);
	endtask
	task automatic chk(input string nm, input logic [7:0] ex, got);
		nTests++;
		if (got !== ex) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", nTests, errors);
		if (errors == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rdSeen) chk("read data", rq.pop_front(), regRdData);
		if (prSeen) chk("prog data", pq.pop_front(), progRdData);
		rdSeen <= regRd;
		prSeen <= progRd;
	end
	initial begin
		#1000000;
		errors++;
		tally_and_finish();
	end
	initial begin
		int n;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		foreach (regs[i]) rd(regs[i], 8'h00);
		op(1'h1, 1'h0, 8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		repeat (20) op(1'h0, 1'h0, 8'h00, 8'h00);
		d = {1'h0, 7'($random(seed))} | 8'h01;
		a = 7'($random(seed));
		op(1'h1, 1'h0, 8'h9A, d);
		op(1'h1, 1'h0, 8'h9B, {1'h1, a});
		op(1'h1, 1'h0, 8'h9C, 8'h04);
		unl(2, 8'h06);
		rd(8'h9C, 8'h04);
		op(1'h1, 1'h0, 8'h9C, 8'h00);
		unl(1, 8'h06);
		rd(8'h9C, 8'h04);
		op(1'h1, 1'h0, 8'h9C, 8'h04);
		unl(1, 8'h06);
		rd(8'h9C, 8'h06);
		op(1'h1, 1'h0, 8'h9C, 8'h01);
		rd(8'h9C, 8'h02);
		n = 0;
		while (writeBusy !== 1'h0 && n < 40) begin
			op(1'h0, 1'h0, 8'h00, 8'h00);
			n++;
		end
		rd(8'h0C, 8'h80);
		op(1'h1, 1'h0, 8'h9C, 8'h01);
		rd(8'h9A, d);
		rd(8'h9A, d);
		op(1'h1, 1'h0, 8'h0C, 8'h00);
		rd(8'h0C, 8'h00);
		progAddr <= a;
		progRd <= 1'h1;
		pq.push_back(d);
		op(1'h0, 1'h0, 8'h00, 8'h00);
		dataProtect <= 1'h1;
		pq.push_back(8'h00);
		op(1'h0, 1'h0, 8'h00, 8'h00);
		progRd <= 1'h0;
		op(1'h1, 1'h0, 8'h9B, {1'h0, a});
		op(1'h1, 1'h0, 8'h9C, 8'h04);
		unl(1, 8'h06);
		repeat (7) op(1'h0, 1'h0, 8'h00, 8'h00);
		watchdogReset <= 1'h1;
		op(1'h0, 1'h0, 8'h00, 8'h00);
		watchdogReset <= 1'h0;
		rd(8'h9C, 8'h08);
		rd(8'h9A, 8'h00);
		rd(8'h9B, 8'h00);
		op(1'h1, 1'h0, 8'h9A, 8'h5A);
		extResetPin_b <= 1'h0;
		repeat (3) op(1'h0, 1'h0, 8'h00, 8'h00);
		extResetPin_b <= 1'h1;
		repeat (3) op(1'h0, 1'h0, 8'h00, 8'h00);
		rd(8'h9A, 8'h00);
		rd(8'h9C, 8'h08);
		op(1'h1, 1'h0, 8'h9C, 8'h00);
		rd(8'h9C, 8'h00);
		repeat (2) op(1'h0, 1'h0, 8'h00, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
